/* File: hw/spi_port_cfg.svh */
`ifndef SPI_PORT_CFG_SVH
`define SPI_PORT_CFG_SVH

// ---------------------------------------------------------------
// Widths
// ---------------------------------------------------------------
`define SPI_WORD_BITS 8
`define SPI_DIV_BITS 8
`define SPI_CNT_BITS 5

// ---------------------------------------------------------------
// Counts and reset values
// ---------------------------------------------------------------
`define SPI_LAST_EDGE 5'h0F
`define SPI_DIV_ONE 8'h01
`define SPI_CS_IDLE 2'h3

`endif

/* File: hw/spi_port_pkg.sv */
`include "spi_port_cfg.svh"

package spi_port_pkg;

  // ---------------------------------------------------------------
  // Transfer sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_XFER = 3'b010,
    ST_DONE = 3'b100
  } xfer_state_t;

  // ---------------------------------------------------------------
  // Static configuration bits from software
  // ---------------------------------------------------------------
  typedef struct packed {
    logic master_mode;
    logic clock_polarity;
    logic clock_phase_select;
    logic [1:0] hold_select_after_last;
    logic mode_fault_detect_off;
    logic chip_select;
    logic [`SPI_DIV_BITS-1:0] serial_clock_divider1;
    logic [`SPI_DIV_BITS-1:0] serial_clock_divider0;
  } port_cfg_t;

  // ---------------------------------------------------------------
  // Divider state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [`SPI_DIV_BITS-1:0] count;
    logic tick;
  } clkdiv_state_t;

  // ---------------------------------------------------------------
  // Port core state
  // ---------------------------------------------------------------
  typedef struct packed {
    xfer_state_t state;
    logic enabled;
    logic mode_fault;
    logic transmit_empty_flag;
    logic [`SPI_WORD_BITS-1:0] transmit_data_holding;
    logic [`SPI_WORD_BITS-1:0] tx_shift;
    logic [`SPI_WORD_BITS-1:0] rx_shift;
    logic [`SPI_WORD_BITS-1:0] receive_holding_data;
    logic receive_ready_flag;
    logic sdo;
    logic sdo_oe;
    logic sck;
    logic sck_oe;
    logic [1:0] cs_n;
    logic active_cs;
    logic extra;
    logic [`SPI_CNT_BITS-1:0] edge_cnt;
    logic glitch_armed;
    logic last_polarity;
    logic sck_s1;
    logic sck_s2;
    logic sck_s3;
    logic ss_s1;
    logic ss_s2;
    logic ss_s3;
    logic sdi_s1;
    logic sdi_s2;
  } core_state_t;

endpackage : spi_port_pkg

/* File: hw/spi_clk_div.sv */
`timescale 1ns/1ns
`include "spi_port_cfg.svh"

module spi_clk_div
  import spi_port_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [`SPI_DIV_BITS-1:0] divider,
  output logic tick
);

  clkdiv_state_t s; // Divider registers
  clkdiv_state_t next_s; // Next divider registers

  // ---------------------------------------------------------------
  // Tick every divider cycles while running; zero acts as one
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (!run) begin
      // Restart cleanly so each transfer begins with a full period
      next_s.count = `SPI_DIV_ONE;
    end else if (s.count >= divider) begin
      next_s.tick = 1'b1;
      next_s.count = `SPI_DIV_ONE;
    end else begin
      next_s.count = s.count + `SPI_DIV_ONE;
    end
  end

  // Register the divider state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '{count: `SPI_DIV_ONE, tick: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;

endmodule : spi_clk_div

/* File: hw/spi_port.sv */
`timescale 1ns/1ns
`include "spi_port_cfg.svh"

module spi_port
  import spi_port_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire port_cfg_t CONFIG,
  input wire logic ENABLE_CMD,
  input wire logic DISABLE_CMD,
  input wire logic SOFT_RESET,
  input wire logic TX_WRITE,
  input wire logic [`SPI_WORD_BITS-1:0] TX_DATA,
  input wire logic RX_READ,
  output logic [`SPI_WORD_BITS-1:0] RX_DATA,
  output logic RECEIVE_READY_FLAG,
  output logic TRANSMIT_EMPTY_FLAG,
  output logic PORT_ENABLED,
  output logic MODE_FAULT,
  input wire logic SCK_IN,
  output logic SCK_OUT,
  output logic SCK_OE,
  input wire logic SS_N_IN,
  input wire logic SDI,
  output logic SDO,
  output logic SDO_OE,
  output logic [1:0] CS_N
);

  // ---------------------------------------------------------------
  // Reset image and helpers
  // ---------------------------------------------------------------
  localparam core_state_t CORE_RESET = '{
    state: ST_IDLE,
    transmit_empty_flag: 1'b1,
    cs_n: `SPI_CS_IDLE,
    ss_s1: 1'b1,
    ss_s2: 1'b1,
    ss_s3: 1'b1,
    default: '0
  };

  // Divider value of one, the case that misbehaves
  function automatic logic div_is_one(input logic [`SPI_DIV_BITS-1:0] d);
    div_is_one = (d == `SPI_DIV_ONE);
  endfunction : div_is_one

  // Active-low select pattern for one chip select
  function automatic logic [1:0] cs_pattern(input logic cs);
    cs_pattern = cs ? 2'h1 : 2'h2;
  endfunction : cs_pattern

  core_state_t s; // Registered state
  core_state_t next_s; // Next state
  logic div_tick; // Master clock half-period tick
  logic div_run; // Divider runs during master shifting
  logic [`SPI_DIV_BITS-1:0] div_active; // Divider of the selected chip select
  logic [`SPI_DIV_BITS-1:0] div_other; // Divider of the other chip select
  logic start_block; // Hold-select hang condition
  logic extra_cond; // Extra clock pulse condition
  logic slave_sel; // Slave select seen low
  logic ss_fall; // Slave select asserted
  logic ss_rise; // Slave select released
  logic s_lead; // Slave leading clock edge
  logic s_trail; // Slave trailing clock edge
  logic lead; // Leading edge in the active mode
  logic trail; // Trailing edge in the active mode
  logic sample; // Capture edge
  logic change; // Output change edge

  // ---------------------------------------------------------------
  // Master clock divider
  // ---------------------------------------------------------------
  assign div_run = (s.state == ST_XFER) && CONFIG.master_mode && !s.extra;
  assign div_active = s.active_cs ? CONFIG.serial_clock_divider1 : CONFIG.serial_clock_divider0;
  assign div_other = s.active_cs ? CONFIG.serial_clock_divider0 : CONFIG.serial_clock_divider1;

  spi_clk_div spi_clk_div_inst (
    .clk(CLK),
    .rst(RST),
    .run(div_run),
    .divider(div_active),
    .tick(div_tick)
  );

  // ---------------------------------------------------------------
  // Edge decode
  // ---------------------------------------------------------------
  always_comb begin
    // Fault detection with select-zero hold stalls every master start
    start_block = CONFIG.hold_select_after_last[0] && !CONFIG.mode_fault_detect_off;
    // Mixed dividers with idle-high clock and phase select zero
    extra_cond = !div_is_one(CONFIG.chip_select ? CONFIG.serial_clock_divider1
                                                : CONFIG.serial_clock_divider0)
                 && div_is_one(CONFIG.chip_select ? CONFIG.serial_clock_divider0
                                                  : CONFIG.serial_clock_divider1)
                 && CONFIG.clock_polarity && !CONFIG.clock_phase_select;
    slave_sel = !s.ss_s2;
    ss_fall = s.ss_s3 && !s.ss_s2;
    ss_rise = !s.ss_s3 && s.ss_s2;
    s_lead = (s.sck_s2 ^ s.sck_s3) && (s.sck_s2 != CONFIG.clock_polarity);
    s_trail = (s.sck_s2 ^ s.sck_s3) && (s.sck_s2 == CONFIG.clock_polarity);
    if (CONFIG.master_mode) begin
      // Master edges come from the divider toggling the clock
      lead = div_tick && (s.state == ST_XFER) && (s.sck == CONFIG.clock_polarity);
      trail = div_tick && (s.state == ST_XFER) && (s.sck != CONFIG.clock_polarity);
    end else begin
      // Slave edges come from the synchronised pin
      lead = s_lead && slave_sel && (s.state == ST_XFER);
      trail = s_trail && slave_sel && (s.state == ST_XFER);
    end
    sample = CONFIG.clock_phase_select ? lead : trail;
    change = CONFIG.clock_phase_select ? trail : lead;
  end

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    // Two-stage synchronisers for the pins
    next_s.sck_s1 = SCK_IN;
    next_s.sck_s2 = s.sck_s1;
    next_s.sck_s3 = s.sck_s2;
    next_s.ss_s1 = SS_N_IN;
    next_s.ss_s2 = s.ss_s1;
    next_s.ss_s3 = s.ss_s2;
    next_s.sdi_s1 = SDI;
    next_s.sdi_s2 = s.sdi_s1;
    next_s.last_polarity = CONFIG.clock_polarity;

    // Enable and disable commands
    if (ENABLE_CMD) begin
      next_s.enabled = 1'b1;
      if (!CONFIG.master_mode) begin
        next_s.glitch_armed = 1'b1;
      end
    end
    if (DISABLE_CMD && CONFIG.master_mode) begin
      // Slave ports keep running; empty flag is left alone
      next_s.enabled = 1'b0;
    end
    if (s.glitch_armed && (CONFIG.clock_polarity != s.last_polarity)) begin
      // Polarity toggle disarms the false ready source
      next_s.glitch_armed = 1'b0;
    end

    // Mode fault: another master drives our select low
    if (CONFIG.master_mode && s.enabled && !CONFIG.mode_fault_detect_off && slave_sel) begin
      next_s.mode_fault = 1'b1;
      next_s.enabled = 1'b0;
    end

    // Reading holding data clears ready; later sets win
    if (RX_READ) begin
      next_s.receive_ready_flag = 1'b0;
    end
    if (ENABLE_CMD && !CONFIG.master_mode) begin
      next_s.receive_ready_flag = 1'b1;
    end

    // Transfer sequencer
    unique case (s.state)
      ST_IDLE: begin
        if (CONFIG.master_mode) begin
          if (s.enabled && !s.transmit_empty_flag && !start_block) begin
            next_s.state = ST_XFER;
            next_s.transmit_empty_flag = 1'b1;
            next_s.active_cs = CONFIG.chip_select;
            next_s.cs_n = cs_pattern(CONFIG.chip_select);
            next_s.edge_cnt = '0;
            next_s.sck = ~CONFIG.clock_polarity;
            next_s.extra = extra_cond;
            if (!extra_cond) begin
              next_s.sck = CONFIG.clock_polarity;
            end
            if (CONFIG.clock_phase_select) begin
              next_s.sdo = s.transmit_data_holding[`SPI_WORD_BITS-1];
              next_s.tx_shift = s.transmit_data_holding << 1;
            end else begin
              next_s.tx_shift = s.transmit_data_holding;
            end
          end else begin
            next_s.sck = CONFIG.clock_polarity;
          end
        end else if (s.enabled && ss_fall) begin
          next_s.state = ST_XFER;
          next_s.edge_cnt = '0;
          if (s.glitch_armed) begin
            next_s.receive_ready_flag = 1'b1;
          end
          if (!s.transmit_empty_flag) begin
            next_s.transmit_empty_flag = 1'b1;
            next_s.tx_shift = s.transmit_data_holding;
          end else begin
            // Nothing to send: zeros go out and nobody is told
            next_s.tx_shift = '0;
          end
          if (CONFIG.clock_phase_select) begin
            next_s.sdo = next_s.tx_shift[`SPI_WORD_BITS-1];
            next_s.tx_shift = next_s.tx_shift << 1;
          end
        end
      end
      ST_XFER: begin
        if (s.extra) begin
          // Close the stray pulse before the real clocking
          next_s.extra = 1'b0;
          next_s.sck = CONFIG.clock_polarity;
        end else if (!CONFIG.master_mode && ss_rise) begin
          // Select released early ends the word
          next_s.state = ST_DONE;
        end else if (lead || trail) begin
          if (CONFIG.master_mode) begin
            next_s.sck = ~s.sck;
          end
          next_s.edge_cnt = s.edge_cnt + 1'b1;
          if (s.edge_cnt == `SPI_LAST_EDGE) begin
            next_s.state = ST_DONE;
          end
        end
        if (sample) begin
          next_s.rx_shift = {s.rx_shift[`SPI_WORD_BITS-2:0], s.sdi_s2};
        end
        if (change) begin
          next_s.sdo = s.tx_shift[`SPI_WORD_BITS-1];
          next_s.tx_shift = s.tx_shift << 1;
        end
      end
      ST_DONE: begin
        next_s.state = ST_IDLE;
        next_s.receive_holding_data = s.rx_shift;
        next_s.receive_ready_flag = 1'b1;
        if (!(CONFIG.master_mode && CONFIG.hold_select_after_last[s.active_cs])) begin
          next_s.cs_n = `SPI_CS_IDLE;
        end
      end
    endcase

    // Writes land only while enabled; disabled words vanish
    if (TX_WRITE && s.enabled) begin
      next_s.transmit_data_holding = TX_DATA;
      next_s.transmit_empty_flag = 1'b0;
    end

    // Pin drivers
    next_s.sck_oe = CONFIG.master_mode && next_s.enabled;
    next_s.sdo_oe = CONFIG.master_mode ? next_s.enabled : (next_s.enabled && slave_sel);
    if (!CONFIG.master_mode) begin
      next_s.cs_n = `SPI_CS_IDLE;
    end

    // Soft reset returns every core register to its reset value; the divider is not reset
    if (SOFT_RESET) begin
      next_s = CORE_RESET;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s <= CORE_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // Outputs straight from registers
  // ---------------------------------------------------------------
  assign RX_DATA = s.receive_holding_data;
  assign RECEIVE_READY_FLAG = s.receive_ready_flag;
  assign TRANSMIT_EMPTY_FLAG = s.transmit_empty_flag;
  assign PORT_ENABLED = s.enabled;
  assign MODE_FAULT = s.mode_fault;
  assign SCK_OUT = s.sck;
  assign SCK_OE = s.sck_oe;
  assign SDO = s.sdo;
  assign SDO_OE = s.sdo_oe;
  assign CS_N = s.cs_n;

endmodule : spi_port

/* File: dv/spi_port_properties.sv */
`timescale 1ns/1ns
`include "spi_port_cfg.svh"

// ---------------------------------------------------------------
// Port checker on top-level pins
// ---------------------------------------------------------------
module spi_port_properties
  import spi_port_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire port_cfg_t CONFIG,
  input wire logic ENABLE_CMD,
  input wire logic DISABLE_CMD,
  input wire logic SOFT_RESET,
  input wire logic TX_WRITE,
  input wire logic [`SPI_WORD_BITS-1:0] TX_DATA,
  input wire logic RX_READ,
  input wire logic [`SPI_WORD_BITS-1:0] RX_DATA,
  input wire logic RECEIVE_READY_FLAG,
  input wire logic TRANSMIT_EMPTY_FLAG,
  input wire logic PORT_ENABLED,
  input wire logic MODE_FAULT,
  input wire logic SCK_IN,
  input wire logic SCK_OUT,
  input wire logic SCK_OE,
  input wire logic SS_N_IN,
  input wire logic SDI,
  input wire logic SDO,
  input wire logic SDO_OE,
  input wire logic [1:0] CS_N
);
  // One clock domain, checks off during reset
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  a_soft_reset_image: assert property (SOFT_RESET |=> !PORT_ENABLED && TRANSMIT_EMPTY_FLAG
    && !RECEIVE_READY_FLAG && CS_N == `SPI_CS_IDLE && RX_DATA == 8'h00)
    else $error("soft reset leaves wrong state");
  a_slave_enable_ready: assert property (ENABLE_CMD && !CONFIG.master_mode && !SOFT_RESET
    |-> ##[1:2] PORT_ENABLED && RECEIVE_READY_FLAG)
    else $error("slave enable without false ready");
  a_slave_disable_kept: assert property (PORT_ENABLED && DISABLE_CMD && !CONFIG.master_mode
    && !SOFT_RESET |=> PORT_ENABLED)
    else $error("slave port stopped by disable");
  a_master_disable_acts: assert property (CONFIG.master_mode && PORT_ENABLED && DISABLE_CMD
    && !ENABLE_CMD && !SOFT_RESET |-> ##[1:2] !PORT_ENABLED)
    else $error("master disable ignored");
  a_disabled_write_dropped: assert property (!PORT_ENABLED && TX_WRITE && !ENABLE_CMD
    && TRANSMIT_EMPTY_FLAG && !SOFT_RESET |=> TRANSMIT_EMPTY_FLAG [*2])
    else $error("write while disabled cleared empty flag");
  a_write_clears_empty: assert property (PORT_ENABLED && TX_WRITE && !DISABLE_CMD
    && !SOFT_RESET |-> ##[1:2] !TRANSMIT_EMPTY_FLAG)
    else $error("accepted write did not clear empty flag");
  a_hold_blocks_start: assert property (PORT_ENABLED && CONFIG.hold_select_after_last[0]
    && !CONFIG.mode_fault_detect_off && CS_N == `SPI_CS_IDLE && !SOFT_RESET |=> CS_N == 2'h3)
    else $error("transfer started while blocked");
  a_fault_detect_off: assert property (CONFIG.mode_fault_detect_off && !MODE_FAULT
    && !SOFT_RESET |=> !MODE_FAULT)
    else $error("mode fault with detection off");
  a_fault_disables: assert property ($rose(MODE_FAULT) |-> !PORT_ENABLED
    && CONFIG.master_mode && !CONFIG.mode_fault_detect_off)
    else $error("mode fault left port enabled");
  a_load_with_select: assert property (CONFIG.master_mode && $fell(CS_N[0])
    |-> TRANSMIT_EMPTY_FLAG)
    else $error("select asserted without shifter load");
endmodule : spi_port_properties

bind spi_port spi_port_properties spi_port_properties_inst (.CLK(CLK), .RST(RST),
  .CONFIG(CONFIG), .ENABLE_CMD(ENABLE_CMD), .DISABLE_CMD(DISABLE_CMD),
  .SOFT_RESET(SOFT_RESET), .TX_WRITE(TX_WRITE), .TX_DATA(TX_DATA), .RX_READ(RX_READ),
  .RX_DATA(RX_DATA), .RECEIVE_READY_FLAG(RECEIVE_READY_FLAG),
  .TRANSMIT_EMPTY_FLAG(TRANSMIT_EMPTY_FLAG), .PORT_ENABLED(PORT_ENABLED),
  .MODE_FAULT(MODE_FAULT), .SCK_IN(SCK_IN), .SCK_OUT(SCK_OUT), .SCK_OE(SCK_OE),
  .SS_N_IN(SS_N_IN), .SDI(SDI), .SDO(SDO), .SDO_OE(SDO_OE), .CS_N(CS_N));

/* File: dv/spi_slave_model.sv */
`timescale 1ns/1ns

// ---------------------------------------------------------------
// External slave: idle-low clock, samples on leading edge
// ---------------------------------------------------------------
module spi_slave_model #(
  parameter logic [7:0] REPLY = 8'h3C
) (
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic [7:0] rx_word
);
  int idx; // Next reply bit to present
  initial begin
    miso = 1'b0;
    rx_word = 8'h00;
    idx = 0;
  end
  // Select falling presents the reply MSB
  always @(negedge cs_n) begin
    miso = REPLY[7];
    idx = 6;
  end
  // Trailing edge moves on while bits remain
  always @(negedge sck) begin
    if (!cs_n && idx >= 0) begin
      miso = REPLY[idx];
      idx = idx - 1;
    end
  end
  // Leading edge captures the port's word MSB first
  always @(posedge sck) begin
    if (!cs_n) begin
      rx_word = {rx_word[6:0], mosi};
    end
  end
  // Released line shows the inverse of its last level
  always @(posedge cs_n) begin
    miso = ~miso;
  end
endmodule : spi_slave_model

/* File: dv/spi_port_tb.sv */
`timescale 1ns/1ns
`include "spi_port_cfg.svh"

// ---------------------------------------------------------------
// Port testbench
// ---------------------------------------------------------------
module spi_port_tb
  import spi_port_pkg::*;
;
  logic clk, rst, sck_in, ss_n_in, sdi, last_sck;
  logic rx_ready, tx_empty, enabled, fault, sck_out, sck_oe, sdo, sdo_oe;
  logic [4:0] cmd; // Enable, disable, soft reset, write, read pulses
  logic [1:0] cs_n, cs_and;
  logic [7:0] tx_data, rx_data, model_rx;
  logic [7:0] slave_word; // Word seen on the port's data pin in slave mode
  port_cfg_t cfg;
  int fail_count, cmp_count, toggles, cycles;

  spi_port spi_port_inst (.CLK(clk), .RST(rst), .CONFIG(cfg), .ENABLE_CMD(cmd[4]),
    .DISABLE_CMD(cmd[3]), .SOFT_RESET(cmd[2]), .TX_WRITE(cmd[1]), .TX_DATA(tx_data),
    .RX_READ(cmd[0]), .RX_DATA(rx_data), .RECEIVE_READY_FLAG(rx_ready),
    .TRANSMIT_EMPTY_FLAG(tx_empty), .PORT_ENABLED(enabled), .MODE_FAULT(fault),
    .SCK_IN(sck_in), .SCK_OUT(sck_out), .SCK_OE(sck_oe), .SS_N_IN(ss_n_in), .SDI(sdi),
    .SDO(sdo), .SDO_OE(sdo_oe), .CS_N(cs_n));
  spi_slave_model spi_slave_model_inst (.sck(sck_out), .cs_n(cs_n[0]), .mosi(sdo),
    .miso(sdi), .rx_word(model_rx));

  // Clock at 125 MHz
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Serial clock edge count, select history and hang guard
  always @(posedge clk) begin
    cycles++;
    if (sck_out !== last_sck) toggles++;
    last_sck = sck_out;
    cs_and = cs_and & cs_n;
    if (cycles == 20000) begin
      fail_count++;
      finish_test();
    end
  end

  task finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test
  task chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task pulse(input logic [4:0] p);
    @(negedge clk);
    cmd = p;
    @(negedge clk);
    cmd = 5'h00;
  endtask : pulse
  // Bounded wait for the receive flag
  task wait_ready();
    for (int i = 0; i < 600 && rx_ready !== 1'b1; i++) @(negedge clk);
  endtask : wait_ready
  // Master, select 0, idle-low clock, divider 4 on both selects
  task set_master();
    cfg = '0;
    cfg.master_mode = 1'b1;
    cfg.clock_phase_select = 1'b1;
    cfg.serial_clock_divider0 = 8'h04;
    cfg.serial_clock_divider1 = 8'h04;
    tick(4);
  endtask : set_master
  // Clear ready, send one word, wait for its end
  task do_xfer(input logic [7:0] w);
    pulse(5'h01);
    tick(2);
    toggles = 0;
    cs_and = 2'h3;
    tx_data = w;
    pulse(5'h02);
    wait_ready();
    tick(2);
  endtask : do_xfer
  // External master on the slave pins: idle-low clock, one word
  task slv_xfer(output logic [7:0] got);
    got = 8'h00;
    ss_n_in = 1'b0;
    tick(6);
    repeat (8) begin
      got = {got[6:0], sdo};
      sck_in = 1'b1;
      tick(4);
      sck_in = 1'b0;
      tick(4);
    end
    ss_n_in = 1'b1;
    tick(6);
  endtask : slv_xfer

  task t_reset();
    chk({4'h0, enabled, tx_empty, rx_ready, fault}, 8'h04);
    chk({6'h00, cs_n}, 8'h03);
    chk(rx_data, 8'h00);
    $display("test reset done");
  endtask : t_reset
  task t_master();
    set_master();
    pulse(5'h10);
    do_xfer(8'hA5);
    chk({7'h00, rx_ready}, 8'h01);
    chk(rx_data, 8'h3C);
    chk(model_rx, 8'hA5);
    chk(toggles[7:0], 8'h10);
    chk({6'h00, cs_and}, 8'h02);
    chk({6'h00, cs_n}, 8'h03);
    chk({6'h00, sck_oe, sdo_oe}, 8'h03);
    $display("test master transfer done");
  endtask : t_master
  task t_extra_pulse();
    cfg.chip_select = 1'b1;
    cfg.clock_polarity = 1'b1;
    cfg.clock_phase_select = 1'b0;
    cfg.serial_clock_divider0 = 8'h01;
    tick(4);
    do_xfer(8'hC3);
    chk(toggles[7:0], 8'h12);
    chk({6'h00, cs_and}, 8'h01);
    cfg.serial_clock_divider1 = 8'h01;
    tick(4);
    do_xfer(8'h3C);
    chk(toggles[7:0], 8'h10);
    $display("test extra pulse done");
  endtask : t_extra_pulse
  task t_disabled();
    set_master();
    pulse(5'h08);
    tick(2);
    chk({6'h00, enabled, tx_empty}, 8'h01);
    tx_data = 8'hFF;
    repeat (3) pulse(5'h02);
    tick(20);
    chk({5'h00, enabled, cs_n}, 8'h03);
    chk({7'h00, tx_empty}, 8'h01);
    pulse(5'h10);
    do_xfer(8'h96);
    chk(model_rx, 8'h96);
    $display("test disabled writes done");
  endtask : t_disabled
  task t_hold();
    cfg.hold_select_after_last = 2'h1;
    tick(4);
    pulse(5'h01);
    tx_data = 8'h5A;
    pulse(5'h02);
    tick(60);
    chk({5'h00, tx_empty, cs_n}, 8'h03);
    cfg.mode_fault_detect_off = 1'b1;
    wait_ready();
    tick(2);
    chk(model_rx, 8'h5A);
    chk(rx_data, 8'h3C);
    chk({6'h00, cs_n}, 8'h02);
    pulse(5'h04);
    tick(1);
    chk({6'h00, cs_n}, 8'h03);
    set_master();
    pulse(5'h10);
    ss_n_in = 1'b0;
    tick(8);
    chk({6'h00, fault, enabled}, 8'h02);
    ss_n_in = 1'b1;
    pulse(5'h04);
    tick(1);
    chk({7'h00, fault}, 8'h00);
    $display("test hold and fault done");
  endtask : t_hold
  task t_slave();
    cfg = '0;
    cfg.clock_phase_select = 1'b1;
    tick(4);
    pulse(5'h10);
    tick(1);
    chk({6'h00, enabled, rx_ready}, 8'h03);
    cfg.clock_polarity = 1'b1;
    tick(2);
    cfg.clock_polarity = 1'b0;
    tick(2);
    pulse(5'h01);
    tick(1);
    chk({7'h00, rx_ready}, 8'h00);
    // Released partner data line idles high, so ones come in
    tx_data = 8'h96;
    pulse(5'h02);
    slv_xfer(slave_word);
    chk(slave_word, 8'h96);
    chk(rx_data, 8'hFF);
    chk({6'h00, tx_empty, rx_ready}, 8'h03);
    // Nothing written: zeros go out and no flag reports it
    pulse(5'h01);
    slv_xfer(slave_word);
    chk(slave_word, 8'h00);
    chk({6'h00, tx_empty, rx_ready}, 8'h03);
    pulse(5'h08);
    tick(2);
    chk({7'h00, enabled}, 8'h01);
    pulse(5'h04);
    tick(1);
    chk({5'h00, enabled, tx_empty, rx_ready}, 8'h02);
    // Fresh enable without the polarity toggle: select fall sets false ready
    pulse(5'h10);
    pulse(5'h01);
    chk({7'h00, rx_ready}, 8'h00);
    ss_n_in = 1'b0;
    tick(4);
    chk({7'h00, rx_ready}, 8'h01);
    ss_n_in = 1'b1;
    tick(6);
    $display("test slave done");
  endtask : t_slave

  // Main sequence
  initial begin
    cfg = '0;
    cmd = 5'h00;
    tx_data = 8'h00;
    sck_in = 1'b0;
    ss_n_in = 1'b1;
    rst = 1'b1;
    last_sck = 1'b0;
    cs_and = 2'h3;
    fail_count = 0;
    cmp_count = 0;
    toggles = 0;
    cycles = 0;
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_master();
    t_extra_pulse();
    t_disabled();
    t_hold();
    t_slave();
    finish_test();
  end
endmodule : spi_port_tb
